// >>> rtl/rbf_regs.svh
// register indices, field positions, reset values and timing counts of the regulator control
`ifndef RBF_REGS_SVH
`define RBF_REGS_SVH

// =====================================================================
// register indices (byte address on the register bus is four times these)
`define RBF_IDX_SOFT_RESET 8'h00
`define RBF_IDX_VOUT_REF 8'h01
`define RBF_IDX_CONTROL 8'h02
`define RBF_IDX_STATUS 8'h03
`define RBF_IDX_MFR_ID 8'h40
`define RBF_IDX_DEV_ID 8'h41

// =====================================================================
// field positions and reset values
`define RBF_SOFT_RESET_BIT 0
`define RBF_CTRL_FORCED_BIT 2
`define RBF_CTRL_BYPASS_BIT 3
`define RBF_ST_SUPPLY_OK_BIT 0
`define RBF_ST_FAULT_BIT 1
`define RBF_ST_SOFTSTART_BIT 2
`define RBF_ST_HS_BIT 3
`define RBF_VOUT_REF_RST 7'h00
`define RBF_CTRL_RST 1'h0

// =====================================================================
// serial bus constants
`define RBF_TARGET_ADDR 7'h70
`define RBF_HS_CODE 5'h01

// =====================================================================
// timing: times in their own unit, cycle counts derived from the clock rate
`define RBF_PCLK_MHZ 50
`define RBF_SS_TIMEOUT_US 1000
`define RBF_PEAK_LIMIT_US 700
`define RBF_RESTART_US 30000
`define RBF_SS_TIMEOUT_CYC (`RBF_SS_TIMEOUT_US * `RBF_PCLK_MHZ)
`define RBF_PEAK_LIMIT_CYC (`RBF_PEAK_LIMIT_US * `RBF_PCLK_MHZ)
`define RBF_RESTART_CYC (`RBF_RESTART_US * `RBF_PCLK_MHZ)
`define RBF_RAMP_STEP_CYC 12'h040

`endif

// >>> rtl/rbf_pkg.sv
// types shared by the regulator control blocks
package rbf_pkg;
	// power sequencer states
	typedef enum logic [1:0] {seq_off, seq_soft, seq_run, seq_fault} rbf_seq_t;
	// serial target states
	typedef enum logic [3:0] {i2c_idle, i2c_addr, i2c_ack_a, i2c_idx, i2c_ack_i, i2c_wdat,
		i2c_ack_w, i2c_rdat, i2c_rack, i2c_wait} rbf_i2c_t;
endpackage

// >>> rtl/rbf_i2c_target.sv
// serial bus target: address match, register index, byte write and read
`timescale 1ns/1ps
`include "rbf_regs.svh"
module rbf_i2c_target (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_pin,
	input wire logic sda_pin_in,
	output logic sda_pin_out,
	output logic sda_pin_oe_n,
	input wire logic [7:0] rd_data,
	output logic [7:0] reg_idx,
	output logic wr_stb,
	output logic [7:0] wr_data,
	output logic hs_mode
);
	typedef struct packed {
		logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
		rbf_pkg::rbf_i2c_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] idx;
		logic rw, oe_n, wr_stb;
		logic [7:0] wr_data;
		logic hs;
	} rbf_i2c_state_t;
	rbf_i2c_state_t r, n;
	logic scl_rise, scl_fall, start_c, stop_c;

	// =====================================================================
	// bus events, seen only after the second synchroniser stage
	assign scl_rise = r.scl_s2 & ~r.scl_d;
	assign scl_fall = ~r.scl_s2 & r.scl_d;
	assign start_c = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
	assign stop_c = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;

	// next state; at 50 MHz a high-speed bit is only a few samples wide, so timing is tight
	always_comb
	begin
		n = r;
		n.scl_s1 = scl_pin;
		n.scl_s2 = r.scl_s1;
		n.scl_d = r.scl_s2;
		n.sda_s1 = sda_pin_in;
		n.sda_s2 = r.sda_s1;
		n.sda_d = r.sda_s2;
		n.wr_stb = 1'b0;
		if (stop_c)
		begin
			n.st = rbf_pkg::i2c_idle;
			n.oe_n = 1'b1;
			n.hs = 1'b0;
		end
		else if (start_c)
		begin
			n.st = rbf_pkg::i2c_addr; // repeated start keeps hs
			n.cnt = 4'h0;
			n.oe_n = 1'b1;
		end
		else if (scl_rise)
		begin
			// data sampled on the rising clock, msb first
			unique case (r.st)
				rbf_pkg::i2c_addr, rbf_pkg::i2c_idx, rbf_pkg::i2c_wdat:
				begin
					n.sh = {r.sh[6:0], r.sda_s2};
					n.cnt = r.cnt + 4'h1;
				end
				rbf_pkg::i2c_rdat: n.cnt = r.cnt + 4'h1;
				rbf_pkg::i2c_rack:
				begin
					if (r.sda_s2)
						n.st = rbf_pkg::i2c_wait; // controller nack ends the read
					else
						n.idx = r.idx + 8'h01;
				end
				default: n.st = r.st;
			endcase
		end
		else if (scl_fall)
		begin
			// the data line only changes while the clock is low
			unique case (r.st)
				rbf_pkg::i2c_addr:
				if (r.cnt == 4'h8)
				begin
					if (r.sh[7:1] == `RBF_TARGET_ADDR)
					begin
						n.oe_n = 1'b0;
						n.rw = r.sh[0];
						n.st = rbf_pkg::i2c_ack_a;
					end
					else if (r.sh[7:3] == `RBF_HS_CODE)
					begin
						n.hs = 1'b1;
						n.st = rbf_pkg::i2c_wait;
					end
					else
						n.st = rbf_pkg::i2c_wait;
				end
				rbf_pkg::i2c_idx:
				if (r.cnt == 4'h8)
				begin
					n.idx = r.sh;
					n.oe_n = 1'b0;
					n.st = rbf_pkg::i2c_ack_i;
				end
				rbf_pkg::i2c_wdat:
				if (r.cnt == 4'h8)
				begin
					n.wr_stb = 1'b1;
					n.wr_data = r.sh;
					n.oe_n = 1'b0;
					n.st = rbf_pkg::i2c_ack_w;
				end
				rbf_pkg::i2c_ack_a:
				begin
					n.cnt = 4'h0;
					n.st = r.rw ? rbf_pkg::i2c_rdat : rbf_pkg::i2c_idx;
					n.sh = rd_data;
					n.oe_n = r.rw ? rd_data[7] : 1'b1;
				end
				rbf_pkg::i2c_ack_i, rbf_pkg::i2c_ack_w:
				begin
					n.cnt = 4'h0;
					n.st = rbf_pkg::i2c_wdat;
					n.oe_n = 1'b1;
					if (r.st == rbf_pkg::i2c_ack_w)
						n.idx = r.idx + 8'h01;
				end
				rbf_pkg::i2c_rdat:
				if (r.cnt == 4'h8)
				begin
					n.oe_n = 1'b1;
					n.st = rbf_pkg::i2c_rack;
				end
				else
				begin
					n.sh = {r.sh[6:0], 1'b0};
					n.oe_n = r.sh[6];
				end
				rbf_pkg::i2c_rack:
				begin
					n.cnt = 4'h0;
					n.st = rbf_pkg::i2c_rdat;
					n.sh = rd_data;
					n.oe_n = rd_data[7];
				end
				default: n.st = r.st;
			endcase
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
				sda_d: 1'b1, st: rbf_pkg::i2c_idle, oe_n: 1'b1, default: '0};
		else
			r <= n;
	end

	assign sda_pin_out = 1'b0; // open drain: only ever pulls low
	assign sda_pin_oe_n = r.oe_n;
	assign reg_idx = r.idx;
	assign wr_stb = r.wr_stb;
	assign wr_data = r.wr_data;
	assign hs_mode = r.hs;

	// =====================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_drive_only_ack: assert property (!r.oe_n |-> r.st inside {rbf_pkg::i2c_ack_a,
		rbf_pkg::i2c_ack_i, rbf_pkg::i2c_ack_w, rbf_pkg::i2c_rdat})
		else $error("data line pulled low outside ack or read");
	a_foreign_addr_nack: assert property (scl_fall && r.st == rbf_pkg::i2c_addr
		&& r.cnt == 4'h8 && r.sh[7:1] != `RBF_TARGET_ADDR |=> r.oe_n)
		else $error("foreign address acknowledged");
	a_hs_code_nack: assert property (scl_fall && r.st == rbf_pkg::i2c_addr && r.cnt == 4'h8
		&& r.sh[7:3] == `RBF_HS_CODE |=> r.oe_n && r.hs)
		else $error("master code acknowledged or hs not entered");
	a_stop_clears_hs: assert property (stop_c |=> !r.hs && r.st == rbf_pkg::i2c_idle)
		else $error("stop did not leave high speed");
	a_read_msb_first: assert property (scl_fall && r.st == rbf_pkg::i2c_rdat
		&& r.cnt != 4'h8 |=> r.oe_n == $past(r.sh[6]))
		else $error("read bit out of order");
	c_hs_entered: cover property (r.hs && start_c);
	c_byte_written: cover property (r.wr_stb);
endmodule

// >>> rtl/rbf_regulator_ctrl.sv
// regulator control: register bus slave, power sequencer, fault supervisor, bridge drive
// =====================================================================
`timescale 1ns/1ps
`include "rbf_regs.svh"
module rbf_regulator_ctrl #(
	parameter int SS_TIMEOUT_CYC = `RBF_SS_TIMEOUT_CYC,
	parameter int PEAK_LIMIT_CYC = `RBF_PEAK_LIMIT_CYC,
	parameter int RESTART_CYC = `RBF_RESTART_CYC,
	parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h01 // arbitrary value
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_pin,
	input wire logic sda_pin_in,
	output logic sda_pin_out,
	output logic sda_pin_oe_n,
	input wire logic en_pin,
	input wire logic vout_ok_pin,
	input wire logic peak_limit_pin,
	input wire logic over_temp_pin,
	input wire logic undervoltage_lockout,
	input wire logic vin_above_target_pin,
	input wire logic mod_pulse_pin,
	output logic input_high_switch,
	output logic input_low_switch,
	output logic output_high_switch,
	output logic output_low_switch,
	output logic out_discharge_on,
	output logic supply_ok_flag_out,
	output logic supply_ok_flag_oe_n,
	output logic [6:0] ref_dac_code,
	output logic light_load_pulse_skip,
	output logic bypass_mode
);
	localparam int NPIN = 7;
	localparam int PIN_EN = 0;
	localparam int PIN_VOK = 1;
	localparam int PIN_PEAK = 2;
	localparam int PIN_OT = 3;
	localparam int PIN_UV = 4;
	localparam int PIN_VINAB = 5;
	localparam int PIN_PULSE = 6;

	typedef struct packed {
		logic [NPIN-1:0] s1, s2;
		rbf_pkg::rbf_seq_t st;
		logic [20:0] tmr;
		logic [20:0] overcurrent_protect;
		logic [11:0] step;
		logic [6:0] ref_code;
		logic [6:0] vout_ref;
		logic bypass, forced;
		logic [31:0] prdata;
		logic pready, pslverr;
		logic [3:0] sw;
		logic discharge, pg_oe_n, llps;
	} rbf_top_state_t;
	rbf_top_state_t r, n;

	logic [NPIN-1:0] pins;
	logic [7:0] i2c_idx, i2c_wdata;
	logic i2c_wr, hs;
	logic [7:0] apb_idx;
	logic apb_hit;
	logic en, vok, peak, ot, uv, vinab, pulse;
	logic fault_now, soft_done;

	// =====================================================================
	// serial target; it runs whatever the enable pin does
	rbf_i2c_target u_i2c (
		.pclk(pclk),
		.presetn(presetn),
		.scl_pin(scl_pin),
		.sda_pin_in(sda_pin_in),
		.sda_pin_out(sda_pin_out),
		.sda_pin_oe_n(sda_pin_oe_n),
		.rd_data(reg_read(r, i2c_idx, hs)),
		.reg_idx(i2c_idx),
		.wr_stb(i2c_wr),
		.wr_data(i2c_wdata),
		.hs_mode(hs)
	);

	// =====================================================================
	// register decode shared by both access paths
	function automatic logic idx_mapped(input logic [7:0] idx);
		return idx inside {`RBF_IDX_SOFT_RESET, `RBF_IDX_VOUT_REF, `RBF_IDX_CONTROL,
			`RBF_IDX_STATUS, `RBF_IDX_MFR_ID, `RBF_IDX_DEV_ID};
	endfunction

	function automatic logic [7:0] reg_read(input rbf_top_state_t s, input logic [7:0] idx,
		input logic hs_in);
		logic [7:0] d;
		d = 8'h00;
		unique case (idx)
			`RBF_IDX_VOUT_REF: d = {1'b0, s.vout_ref};
			`RBF_IDX_CONTROL:
			begin
				d[`RBF_CTRL_BYPASS_BIT] = s.bypass;
				d[`RBF_CTRL_FORCED_BIT] = s.forced;
			end
			`RBF_IDX_STATUS:
			begin
				d[`RBF_ST_SUPPLY_OK_BIT] = s.st == rbf_pkg::seq_run;
				d[`RBF_ST_FAULT_BIT] = s.st == rbf_pkg::seq_fault;
				d[`RBF_ST_SOFTSTART_BIT] = s.st == rbf_pkg::seq_soft;
				d[`RBF_ST_HS_BIT] = hs_in;
			end
			`RBF_IDX_MFR_ID: d = MFR_ID;
			`RBF_IDX_DEV_ID: d = DEV_ID;
			default: d = 8'h00; // soft reset and unmapped read zero
		endcase
		return d;
	endfunction

	// one write; read-only indices quietly ignore it
	function automatic rbf_top_state_t reg_write(input rbf_top_state_t s,
		input logic [7:0] idx, input logic [7:0] d);
		rbf_top_state_t o;
		o = s;
		unique case (idx)
			`RBF_IDX_SOFT_RESET:
			if (d[`RBF_SOFT_RESET_BIT])
			begin
				o.vout_ref = `RBF_VOUT_REF_RST;
				o.bypass = `RBF_CTRL_RST;
				o.forced = `RBF_CTRL_RST;
			end
			`RBF_IDX_VOUT_REF: o.vout_ref = d[6:0];
			`RBF_IDX_CONTROL:
			begin
				o.bypass = d[`RBF_CTRL_BYPASS_BIT];
				o.forced = d[`RBF_CTRL_FORCED_BIT];
			end
			default: o.vout_ref = s.vout_ref;
		endcase
		return o;
	endfunction

	// =====================================================================
	// pin inputs, each through two flip-flops before use
	assign pins = {mod_pulse_pin, vin_above_target_pin, undervoltage_lockout, over_temp_pin,
		peak_limit_pin, vout_ok_pin, en_pin};
	assign en = r.s2[PIN_EN];
	assign vok = r.s2[PIN_VOK];
	assign peak = r.s2[PIN_PEAK];
	assign ot = r.s2[PIN_OT];
	assign uv = r.s2[PIN_UV];
	assign vinab = r.s2[PIN_VINAB];
	assign pulse = r.s2[PIN_PULSE];

	assign apb_idx = paddr[9:2];
	assign apb_hit = paddr[11:10] == 2'h0 && idx_mapped(apb_idx);

	// fault causes; sustained peak current counts only outside bypass
	assign fault_now = ot || uv
		|| (!r.bypass && r.overcurrent_protect == 21'(PEAK_LIMIT_CYC - 1))
		|| (r.st == rbf_pkg::seq_soft && r.tmr == 21'(SS_TIMEOUT_CYC - 1));
	assign soft_done = r.ref_code == r.vout_ref && vok;

	// =====================================================================
	// next state: bus slave, registers, sequencer and drive
	always_comb
	begin
		n = r;
		n.s1 = pins;
		n.s2 = r.s1;

		// bus slave: one wait state, data and error registered for the access phase
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && penable && !r.pready)
		begin
			n.pready = 1'b1;
			n.pslverr = !apb_hit;
			n.prdata = (pwrite || !apb_hit) ? 32'h0000_0000 : {24'h00_0000, reg_read(r, apb_idx, hs)};
		end
		if (psel && penable && r.pready && pwrite && apb_hit)
			n = reg_write(n, apb_idx, pwdata[7:0]);
		// a serial write in the same cycle lands after the bus write
		if (i2c_wr)
			n = reg_write(n, i2c_idx, i2c_wdata);

		// sequencer
		n.tmr = r.tmr + 21'h00_0001;
		n.step = r.step + 12'h001;
		if ((r.st == rbf_pkg::seq_soft || r.st == rbf_pkg::seq_run) && peak && !r.bypass)
			n.overcurrent_protect = r.overcurrent_protect + 21'h00_0001;
		else
			n.overcurrent_protect = 21'h00_0000;
		if (!en && r.st != rbf_pkg::seq_off)
			n.st = rbf_pkg::seq_off;
		else
		begin
			unique case (r.st)
				rbf_pkg::seq_off:
				if (en)
				begin
					n.st = rbf_pkg::seq_soft;
					n.tmr = 21'h00_0000;
					n.step = 12'h000;
					n.ref_code = 7'h00;
				end
				rbf_pkg::seq_soft, rbf_pkg::seq_run:
				begin
					// reference walks one code per step toward the target
					if (r.step == `RBF_RAMP_STEP_CYC - 12'h001)
					begin
						n.step = 12'h000;
						if (r.ref_code < r.vout_ref)
							n.ref_code = r.ref_code + 7'h01;
						else if (r.ref_code > r.vout_ref)
							n.ref_code = r.ref_code - 7'h01;
					end
					if (fault_now)
					begin
						n.st = rbf_pkg::seq_fault;
						n.tmr = 21'h00_0000;
						n.overcurrent_protect = 21'h00_0000;
					end
					else if (r.st == rbf_pkg::seq_soft && soft_done)
						n.st = rbf_pkg::seq_run;
				end
				rbf_pkg::seq_fault:
				if (r.tmr == 21'(RESTART_CYC - 1))
				begin
					n.st = rbf_pkg::seq_soft;
					n.tmr = 21'h00_0000;
					n.step = 12'h000;
					n.ref_code = 7'h00;
				end
			endcase
		end

		// bridge drive from the state being entered; no dead time is inserted here
		n.sw = 4'h0; // {output low, output high, input low, input high}
		if (n.st == rbf_pkg::seq_run && n.bypass)
			n.sw = 4'h5;
		else if (n.st == rbf_pkg::seq_soft || n.st == rbf_pkg::seq_run)
		begin
			if (vinab)
				n.sw = {1'b0, 1'b1, !pulse, pulse};
			else
				n.sw = {pulse, !pulse, 1'b0, 1'b1};
		end
		n.discharge = n.st == rbf_pkg::seq_off;
		n.pg_oe_n = n.st == rbf_pkg::seq_run;
		n.llps = n.bypass || !n.forced; // forced bit is ignored while bypassing
	end

	// =====================================================================
	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r <= '{st: rbf_pkg::seq_off, vout_ref: `RBF_VOUT_REF_RST, discharge: 1'b1,
				llps: 1'b1, default: '0};
		else
			r <= n;
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign input_high_switch = r.sw[0];
	assign input_low_switch = r.sw[1];
	assign output_high_switch = r.sw[2];
	assign output_low_switch = r.sw[3];
	assign out_discharge_on = r.discharge;
	assign supply_ok_flag_out = 1'b0;
	assign supply_ok_flag_oe_n = r.pg_oe_n;
	assign ref_dac_code = r.ref_code;
	assign light_load_pulse_skip = r.llps;
	assign bypass_mode = r.bypass;

	// =====================================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_shutdown_isolated: assert property (r.st == rbf_pkg::seq_off |-> r.sw == 4'h0
		&& r.discharge && !r.pg_oe_n)
		else $error("shutdown not isolated or not discharging");
	a_fault_high_z: assert property (r.st == rbf_pkg::seq_fault |-> r.sw == 4'h0
		&& !r.discharge && !r.pg_oe_n)
		else $error("fault state still switching or flagging good");
	a_ot_fault_now: assert property (en && (ot || uv) && r.st inside {rbf_pkg::seq_soft,
		rbf_pkg::seq_run} |=> r.st == rbf_pkg::seq_fault)
		else $error("temperature or lockout did not fault");
	a_restart_delay: assert property (r.st == rbf_pkg::seq_fault && en
		&& r.tmr == 21'(RESTART_CYC - 1) |=> r.st == rbf_pkg::seq_soft)
		else $error("restart not taken after fault wait");
	a_soft_timeout: assert property (en && !ot && !uv && r.st == rbf_pkg::seq_soft
		&& r.tmr == 21'(SS_TIMEOUT_CYC - 1) |=> r.st == rbf_pkg::seq_fault)
		else $error("soft-start timeout missed");
	a_good_only_run: assert property (r.pg_oe_n |-> r.st == rbf_pkg::seq_run
		&& $past(r.st) inside {rbf_pkg::seq_soft, rbf_pkg::seq_run})
		else $error("power good released outside run");
	a_bypass_static: assert property (r.st == rbf_pkg::seq_run && r.bypass
		&& $past(r.bypass) && $past(r.st) == rbf_pkg::seq_run |-> r.sw == 4'h5)
		else $error("bypass switches not static");
	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("bus access not answered in one wait state");
	c_reach_run: cover property (r.st == rbf_pkg::seq_soft ##1 r.st == rbf_pkg::seq_run);
	c_reach_fault: cover property (r.st == rbf_pkg::seq_run ##1 r.st == rbf_pkg::seq_fault);
	c_restart: cover property (r.st == rbf_pkg::seq_fault ##1 r.st == rbf_pkg::seq_soft);
endmodule

// >>> verification/rbf_i2c_host.sv
// bus controller model: drives the serial clock and pulls the data line
`timescale 1ns/1ps
module rbf_i2c_host (
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	// =====================================================
	// line control
	// both lines released at idle; the clock stands high outside frames
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// start from idle, or repeated start from a low clock
	task automatic start();
		// small offset keeps line edges clear of the block's sampling edge
		#5;
		if (!scl)
		begin
			#40;
			sda_pull = 1'b0;
			#40;
			scl = 1'b1;
			#80;
		end
		sda_pull = 1'b1;
		#80;
		scl = 1'b0;
	endtask

	// data rises with the clock high, bus back to idle
	task automatic stop();
		#40;
		sda_pull = 1'b1;
		#80;
		scl = 1'b1;
		#80;
		sda_pull = 1'b0;
		#80;
	endtask

	// data moves mid low phase, read back mid high phase
	task automatic bit_x(input logic b, output logic s);
		#40;
		sda_pull = !b;
		#40;
		scl = 1'b1;
		#40;
		s = sda;
		#40;
		scl = 1'b0;
	endtask

	// one byte high bit first, then the ninth slot where low means ack
	task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(d[i], s);
			q[i] = s;
		end
		bit_x(ma, s);
		ack = !s;
	endtask
endmodule

// >>> verification/rbf_regulator_ctrl_tb.sv
// self-checking bench for the regulator control block
`timescale 1ns/1ps
module rbf_regulator_ctrl_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, sda_pin_oe_n, scl;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic sda_pull, sda_w, en_pin, vout_ok_pin, peak_limit_pin, over_temp_pin, ack;
	logic undervoltage_lockout, vin_above_target_pin, mod_pulse_pin, input_high_switch;
	logic input_low_switch, output_high_switch, output_low_switch, out_discharge_on;
	logic supply_ok_flag_oe_n, light_load_pulse_skip, bypass_mode;
	logic [6:0] ref_dac_code;
	logic [7:0] rb;
	int bad_count = 0;
	int n_tests = 0;

	// =====================================================
	// design, controller model, pulled-up data wire; short counts keep the run brief
	rbf_regulator_ctrl #(.SS_TIMEOUT_CYC(200), .PEAK_LIMIT_CYC(50), .RESTART_CYC(100),
		.MFR_ID(8'h3C), .DEV_ID(8'h2B)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata,
		.prdata, .pready, .pslverr, .scl_pin(scl), .sda_pin_in(sda_w), .sda_pin_out(),
		.sda_pin_oe_n, .en_pin, .vout_ok_pin, .peak_limit_pin, .over_temp_pin,
		.undervoltage_lockout, .vin_above_target_pin, .mod_pulse_pin, .input_high_switch,
		.input_low_switch, .output_high_switch, .output_low_switch, .out_discharge_on,
		.supply_ok_flag_out(), .supply_ok_flag_oe_n, .ref_dac_code, .light_load_pulse_skip,
		.bypass_mode); // id code values are arbitrary
	assign sda_w = !(sda_pull || !sda_pin_oe_n);
	rbf_i2c_host u_host (.scl, .sda_pull, .sda(sda_w));
	always #10 pclk = ~pclk;

	// =====================================================
	// helpers
	// compare and count
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [3:0] sw();
		return {input_high_switch, input_low_switch, output_high_switch, output_low_switch};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// bounded wait for the flag to reach a level
	task automatic till_ok(input logic v);
		repeat (400)
			if (supply_ok_flag_oe_n !== v)
				@(posedge pclk);
		// a wait that runs out counts as a mismatch
		if (supply_ok_flag_oe_n !== v)
			chk("flag wait", 32'(v), 32'(supply_ok_flag_oe_n));
	endtask
	// one register bus transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait count assumed; only the watchdog ends a hang
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask

	// =====================================================
	// scenarios
	task automatic t_regs();
		chk("reset pins", 8'h0B, {sw(), out_discharge_on, supply_ok_flag_oe_n, sda_pin_oe_n,
			light_load_pulse_skip});
		apb(1, 12'h004, 2);
		apb(0, 12'h004, 0);
		chk("target level", 2, q);
		apb(0, 12'h010, 0);
		chk("unmapped", 32'h0000_0001, {q[30:0], e});
		apb(0, 12'h100, 0);
		chk("maker code", 32'h0000_003C, q);
		apb(0, 12'h104, 0);
		chk("device code", 32'h0000_002B, q);
		apb(1, 12'h000, 1);
		apb(0, 12'h004, 0);
		chk("soft reset", 0, q);
		fin("regs");
	endtask

	// serial write, read, foreign address and fast mode while shut down
	task automatic t_i2c();
		u_host.start();
		u_host.xfer(8'hE0, 1'b1, rb, ack);
		chk("addr ack", 1, 32'(ack));
		u_host.xfer(8'h01, 1'b1, rb, ack);
		u_host.xfer(8'h03, 1'b1, rb, ack);
		u_host.stop();
		apb(0, 12'h004, 0);
		chk("serial write", 3, q);
		u_host.start();
		u_host.xfer(8'hE0, 1'b1, rb, ack);
		u_host.xfer(8'h01, 1'b1, rb, ack);
		u_host.start();
		u_host.xfer(8'hE1, 1'b1, rb, ack);
		u_host.xfer(8'hFF, 1'b1, rb, ack);
		u_host.stop();
		chk("serial read", 3, 32'(rb));
		u_host.start();
		u_host.xfer(8'hE2, 1'b1, rb, ack);
		u_host.stop();
		chk("foreign ack", 0, 32'(ack));
		u_host.start();
		u_host.xfer(8'h0D, 1'b1, rb, ack);
		chk("code ack", 0, 32'(ack));
		apb(0, 12'h00C, 0);
		chk("fast status", 32'h0000_0008, q);
		u_host.start();
		u_host.xfer(8'hE0, 1'b1, rb, ack);
		chk("fast ack", 1, 32'(ack));
		u_host.stop();
		apb(0, 12'h00C, 0);
		chk("fast cleared", 0, q);
		fin("serial");
	endtask

	// soft-start, run and bridge drive
	task automatic t_run();
		apb(1, 12'h004, 2);
		en_pin <= 1'b1;
		cyc(20);
		chk("flag early", 0, 32'(supply_ok_flag_oe_n));
		till_ok(1'b1);
		chk("ramp end", 2, 32'(ref_dac_code));
		chk("flag run", 1, 32'(supply_ok_flag_oe_n));
		cyc(3);
		chk("buck", 6, 32'(sw()));
		vin_above_target_pin <= 1'b0;
		mod_pulse_pin <= 1'b1;
		cyc(6);
		chk("boost", 9, 32'(sw()));
		fin("run");
	endtask

	// faults and timed restart
	task automatic t_fault();
		over_temp_pin <= 1'b1;
		cyc(6);
		chk("hot", 0, 32'({sw(), out_discharge_on, supply_ok_flag_oe_n}));
		over_temp_pin <= 1'b0;
		cyc(60);
		chk("restart wait", 0, 32'(supply_ok_flag_oe_n));
		till_ok(1'b1);
		chk("restarted", 1, 32'(supply_ok_flag_oe_n));
		peak_limit_pin <= 1'b1;
		cyc(38);
		chk("peak short", 1, 32'(supply_ok_flag_oe_n));
		cyc(30);
		chk("peak long", 0, 32'(supply_ok_flag_oe_n));
		peak_limit_pin <= 1'b0;
		till_ok(1'b1);
		undervoltage_lockout <= 1'b1;
		cyc(6);
		chk("lockout", 0, 32'(supply_ok_flag_oe_n));
		undervoltage_lockout <= 1'b0;
		vout_ok_pin <= 1'b0;
		en_pin <= 1'b0;
		cyc(6);
		chk("off", 1, 32'({sw(), out_discharge_on}));
		en_pin <= 1'b1;
		cyc(150);
		apb(0, 12'h00C, 0);
		chk("ss pending", 4, q);
		cyc(80);
		apb(0, 12'h00C, 0);
		chk("ss timeout", 2, q);
		en_pin <= 1'b0;
		vout_ok_pin <= 1'b1;
		cyc(6);
		fin("fault");
	endtask

	// bypass and light-load selection
	task automatic t_bypass();
		en_pin <= 1'b1;
		till_ok(1'b1);
		apb(1, 12'h008, 32'h0000_000C);
		cyc(2);
		chk("bypass", 32'h0000_003A, 32'({bypass_mode, light_load_pulse_skip, sw()}));
		peak_limit_pin <= 1'b1;
		cyc(80);
		chk("bypass peak", 1, 32'(supply_ok_flag_oe_n));
		peak_limit_pin <= 1'b0;
		apb(1, 12'h008, 4);
		cyc(2);
		chk("forced", 0, 32'(light_load_pulse_skip));
		apb(1, 12'h008, 0);
		cyc(2);
		chk("auto", 1, 32'(light_load_pulse_skip));
		fin("bypass");
	endtask

	// =====================================================
	// verdict, main sequence and watchdog
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{en_pin, peak_limit_pin, over_temp_pin, undervoltage_lockout, mod_pulse_pin} = '0;
		vout_ok_pin = 1'b1;
		vin_above_target_pin = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_i2c();
		t_run();
		t_fault();
		t_bypass();
		give_verdict();
	end
	// tests need well under a millisecond
	initial
	begin
		#1000000;
		bad_count++;
		give_verdict();
	end
endmodule
